// ---- rx_recovery_pkg.sv ----
// Purpose: shared constants and types for the async receive front end
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   offsets are byte addresses
package rx_recovery_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] BAUD_OFFSET   = 8'h04;
  localparam logic [7:0] DATA_OFFSET   = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFFSET = 8'h14;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_DOUBLE_BIT  = 1;
  localparam int CTRL_PAR_EN_BIT  = 2;
  localparam int CTRL_PAR_ODD_BIT = 3;
  localparam int CTRL_SIZE_LSB    = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0031;
  localparam logic [15:0] BAUD_RESET = 16'h0036;

  // ----------------------------------------------------------------
  // status / interrupt bit positions
  // ----------------------------------------------------------------
  localparam int ST_DONE_BIT   = 0;
  localparam int ST_FRAME_BIT  = 1;
  localparam int ST_PARITY_BIT = 2;
  localparam int ST_NOISE_BIT  = 3;
  localparam int EVENT_COUNT   = 4;

  // ----------------------------------------------------------------
  // sampling figures
  // ----------------------------------------------------------------
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;

  typedef struct packed {
    logic [8:0] data;
    logic       framing_fault_flag;
    logic       parity_fault_flag;
  } rx_frame_type;

  typedef struct packed {
    logic       enable;
    logic       double_speed;
    logic       parity_en;
    logic       parity_odd;
    logic [3:0] data_bits;
  } rx_config_type;

endpackage

// ---- rx_sampler.sv ----
// Purpose: one-cycle pulse at each baud sample tick
// Assumes: divisor of zero means a tick every clock
// Notes:   divider only, no fractional stepping
`timescale 1ns/100ps
module rx_sampler (
  input  wire logic        clk_sys,  // system clock
  input  wire logic        rst,      // synchronous reset
  input  wire logic [15:0] divisor,  // clocks per sample minus one
  output logic             tick      // sample enable pulse
);
  logic [15:0] count;

  always_ff @(posedge clk_sys) begin
    if (rst || count == 16'h0000) begin
      count <= divisor;
    end else begin
      count <= count - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    tick <= !rst && count == 16'h0000;
  end
endmodule

// ---- async_rx_clock_data_recovery.sv ----
// Purpose: async receive clock and data recovery with AHB-Lite registers
// Assumes: rx_line arrives from a pin; one AHB-Lite master
// Notes:   one receive word held; new frame overwrites it
//
// Contract
// - sample line at 16x baud normally, 8x in double speed
// - idle receiver starts qualification on a high-to-low line edge
// - sample one is the first low sample after idle
// - start judged on samples 8,9,10 or 4,5,6 in double speed
// - two or more low judged samples accept start and lock timing
// - two or more high judged samples reject as noise, back to idle
// - each later bit takes sixteen or eight samples
// - each data, parity, stop bit set by two-of-three centre vote
// - recovery ends at first stop bit; second stop bit ignored
// - low voted first stop bit sets the framing fault flag
// - next falling edge seen right after last stop vote sample
// - receiver and transmitter each take half the mismatch
// - first stop bit moves frame to buffer, sets done flag
// - enabled parity checked against data; mismatch sets fault
`timescale 1ns/100ps
module async_rx_clock_data_recovery (
  input  wire logic        clk_sys,    // system clock, 100 MHz
  input  wire logic        rst,        // synchronous reset, active high
  input  wire logic        rx_line,    // serial input pin
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write strobe
  input  wire logic [2:0]  hsize,      // transfer size
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready
  output logic      [31:0] hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp,      // response, always okay
  output logic             irq         // level interrupt
);
  typedef enum logic [1:0] {idle_st, start_st, bits_st} rx_state_type;

  // ----------------------------------------------------------------
  // registers and bus decode
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] baud;
  localparam int EVENT_COUNT_W = rx_recovery_pkg::EVENT_COUNT;
  logic [EVENT_COUNT_W-1:0] status;
  logic [EVENT_COUNT_W-1:0] irq_en;
  rx_recovery_pkg::rx_frame_type rx_word;
  logic        ph_write;
  logic        ph_read;
  logic [7:0]  ph_addr;
  rx_recovery_pkg::rx_config_type cfg;

  wire addr_take = hsel && hready && htrans[1];
  wire wr_ctrl   = ph_write && ph_addr == rx_recovery_pkg::CTRL_OFFSET;
  wire wr_baud   = ph_write && ph_addr == rx_recovery_pkg::BAUD_OFFSET;
  wire wr_en     = ph_write && ph_addr == rx_recovery_pkg::IRQ_EN_OFFSET;
  wire wr_clr    = ph_write && ph_addr == rx_recovery_pkg::IRQ_CLR_OFFSET;
  wire rd_data   = addr_take && !hwrite
                   && haddr[7:0] == rx_recovery_pkg::DATA_OFFSET;

  assign cfg.enable       = ctrl[rx_recovery_pkg::CTRL_ENABLE_BIT];
  assign cfg.double_speed = ctrl[rx_recovery_pkg::CTRL_DOUBLE_BIT];
  assign cfg.parity_en    = ctrl[rx_recovery_pkg::CTRL_PAR_EN_BIT];
  assign cfg.parity_odd   = ctrl[rx_recovery_pkg::CTRL_PAR_ODD_BIT];
  assign cfg.data_bits    = ctrl[rx_recovery_pkg::CTRL_SIZE_LSB +: 4];

  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      rx_recovery_pkg::CTRL_OFFSET:   rd_mux = ctrl;
      rx_recovery_pkg::BAUD_OFFSET:   rd_mux = {16'h0000, baud};
      rx_recovery_pkg::DATA_OFFSET:   rd_mux = {21'h00_0000, rx_word.parity_fault_flag,
                                                 rx_word.framing_fault_flag,
                                                 rx_word.data};
      rx_recovery_pkg::STATUS_OFFSET: rd_mux = {28'h000_0000, status};
      rx_recovery_pkg::IRQ_EN_OFFSET: rd_mux = {28'h000_0000, irq_en};
      default:                        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ph_write <= 1'b0;
      ph_read  <= 1'b0;
      ph_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      ph_write <= addr_take && hwrite;
      ph_read  <= addr_take && !hwrite;
      ph_addr  <= haddr[7:0];
      hrdata   <= (addr_take && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl   <= rx_recovery_pkg::CTRL_RESET;
      baud   <= rx_recovery_pkg::BAUD_RESET;
      irq_en <= '0;
    end else begin
      if (wr_ctrl) ctrl <= {24'h00_0000, hwdata[7:0]};
      if (wr_baud) baud <= hwdata[15:0];
      if (wr_en)   irq_en <= hwdata[EVENT_COUNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // line synchroniser and sample tick
  // ----------------------------------------------------------------
  logic sync_a;
  logic sync_b;
  logic tick;

  always_ff @(posedge clk_sys) begin
    sync_a <= rst ? 1'b1 : rx_line;
    sync_b <= rst ? 1'b1 : sync_a;
  end

  // exact oversampling tick, own error budget
  rx_sampler u_sampler (
    .clk_sys (clk_sys),
    .rst     (rst),
    .divisor (baud),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // clock and data recovery
  // ----------------------------------------------------------------
  rx_state_type state;
  logic [4:0] sample_no;
  logic [3:0] bit_no;
  logic [2:0] votes;
  logic [8:0] shift;
  logic       par_bit;
  logic       done_pulse;
  logic       frame_err;
  logic       par_err;
  logic       noise_pulse;
  logic       line_prev;

  // samples per bit follow the speed mode
  wire [4:0] per_bit = cfg.double_speed ? rx_recovery_pkg::SAMPLES_DOUBLE
                                        : rx_recovery_pkg::SAMPLES_NORMAL;
  wire [4:0] vote_a  = cfg.double_speed ? rx_recovery_pkg::VOTE_FIRST_DOUBLE
                                        : rx_recovery_pkg::VOTE_FIRST_NORMAL;
  wire [4:0] vote_c  = vote_a + 5'h02;
  wire in_vote  = sample_no >= vote_a && sample_no <= vote_c;
  wire last_vote = sample_no == vote_c;
  // two-of-three majority over the centre samples
  wire majority = (votes[0] & votes[1]) | (votes[0] & votes[2])
                  | (votes[1] & votes[2]);
  wire [3:0] data_n  = cfg.data_bits;
  wire [3:0] par_n   = data_n + {3'b000, cfg.parity_en};
  wire [8:0] aligned = shift >> (4'h9 - data_n);
  wire [8:0] dmask   = 9'h1FF >> (4'h9 - data_n);
  // parity of received data compared with parity bit
  wire par_bad = (^(aligned & dmask)) ^ cfg.parity_odd ^ par_bit;

  always_ff @(posedge clk_sys) begin
    done_pulse  <= 1'b0;
    noise_pulse <= 1'b0;
    if (rst || !cfg.enable) begin
      state     <= idle_st;
      sample_no <= 5'h00;
      bit_no    <= 4'h0;
      votes     <= 3'b000;
      shift     <= 9'h000;
      par_bit   <= 1'b0;
      frame_err <= 1'b0;
      par_err   <= 1'b0;
      line_prev <= 1'b1;
    end else if (tick) begin
      line_prev <= sync_b;
      if (in_vote) votes <= {votes[1:0], sync_b};
      case (state)
        idle_st: begin
          // high-to-low edge, first low sample is one
          if (!sync_b && line_prev) begin
            state     <= start_st;
            sample_no <= 5'h02;
          end
        end
        start_st: begin
          sample_no <= sample_no + 5'h01;
          if (last_vote) begin
            // start vote accepts or rejects as noise
            if ({votes[1:0], sync_b} == 3'b000 ||
                (votes[1:0] == 2'b00) || (votes[1] + votes[0] + sync_b) < 2'd2) begin
              state <= bits_st;
              bit_no <= 4'h0;
            end else begin
              state       <= idle_st;
              noise_pulse <= 1'b1;
            end
          end
          // next window one bit period after sample one
          if (sample_no == per_bit) sample_no <= 5'h01;
        end
        bits_st: begin
          sample_no <= (sample_no == per_bit) ? 5'h01 : sample_no + 5'h01;
          if (last_vote) begin
            if (bit_no < data_n) begin
              shift <= {({votes[1:0], sync_b} >= 3'b011 &&
                         (votes[1] + votes[0] + sync_b) >= 2'd2), shift[8:1]};
            end else if (bit_no < par_n) begin
              par_bit <= (votes[1] + votes[0] + sync_b) >= 2'd2;
            end else begin
              // low stop bit is a framing fault
              // frame complete on first stop bit
              state      <= idle_st;
              sample_no  <= 5'h00;
              frame_err  <= (votes[1] + votes[0] + sync_b) < 2'd2;
              par_err    <= cfg.parity_en && par_bad;
              done_pulse <= 1'b1;
            end
            bit_no <= bit_no + 4'h1;
          end
        end
        default: state <= idle_st;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive word, status and interrupt
  // ----------------------------------------------------------------
  wire [EVENT_COUNT_W-1:0] events = {noise_pulse, done_pulse & par_err,
                                     done_pulse & frame_err, done_pulse};
  wire [EVENT_COUNT_W-1:0] clr_bits = wr_clr ? hwdata[EVENT_COUNT_W-1:0]
                                             : '0;
  wire [EVENT_COUNT_W-1:0] rd_clr = {{(EVENT_COUNT_W-1){1'b0}}, rd_data};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_word <= '0;
      status  <= '0;
      irq     <= 1'b0;
    end else begin
      if (done_pulse) begin
        rx_word.data               <= aligned & dmask;
        rx_word.framing_fault_flag <= frame_err;
        rx_word.parity_fault_flag  <= par_err;
      end
      // set wins over clear
      status <= (status & ~(clr_bits | rd_clr)) | events;
      irq    <= |(((status & ~(clr_bits | rd_clr)) | events) & irq_en);
    end
  end
endmodule

// ---- rx_recovery_assertions.sv ----
// Purpose: port checks for the async receive front end
// Assumes: one AHB-Lite master, zero wait slave
// Notes:   bound to the top module
`timescale 1ns/100ps
module rx_recovery_checker (
  input wire logic        clk_sys,   // clock
  input wire logic        rst,       // reset
  input wire logic        rx_line,   // serial line
  input wire logic        hsel,      // select
  input wire logic [31:0] haddr,     // address
  input wire logic [1:0]  htrans,    // transfer type
  input wire logic        hwrite,    // write
  input wire logic [31:0] hwdata,    // write data
  input wire logic        hready,    // bus ready
  input wire logic [31:0] hrdata,    // read data
  input wire logic        hreadyout, // slave ready
  input wire logic        hresp,     // response
  input wire logic        irq        // interrupt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // bus shadows
  // ----------------------------------------------------------------
  logic        wr_q;
  logic [7:0]  a_q;
  logic [3:0]  en;
  logic [3:0]  act;
  logic [11:0] quiet;
  wire         take = hsel & hready & htrans[1];
  wire         rd_at = take & !hwrite;
  always_ff @(posedge clk_sys) begin
    wr_q  <= take & hwrite & !rst;
    a_q   <= haddr[7:0];
    act   <= {act[2:0], take & !rst};
    quiet <= (rst || !rx_line) ? 12'h000 : quiet + {11'h000, ~&quiet};
  end
  always_ff @(posedge clk_sys) begin
    if (rst)
      en <= 4'h0;
    else if (wr_q && a_q == rx_recovery_pkg::IRQ_EN_OFFSET)
      en <= hwdata[3:0];
  end
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  reset_quiet_a: assert property ($fell(rst) |-> !irq && hrdata == 0)
    else $error("outputs not at reset value");
  unmapped_zero_a: assert property (rd_at && haddr[7:0] == 8'h18
    |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  masked_irq_a: assert property ((en == 4'h0)[*3] |-> !irq)
    else $error("irq high while masked");
  irq_fall_a: assert property ($fell(irq) && !$past(rst) |-> |act)
    else $error("irq dropped without bus access");
  irq_cause_a: assert property ($rose(irq) |-> quiet < 12'hBB8 || |act)
    else $error("irq rose with no frame or access");
  data_width_a: assert property (rd_at
    && haddr[7:0] == rx_recovery_pkg::DATA_OFFSET |=> hrdata[31:11] == 0)
    else $error("data word upper bits set");
  cover property ($rose(irq));
  cover property (rd_at && haddr[7:0] == rx_recovery_pkg::STATUS_OFFSET);
  cover property ($fell(rx_line) ##[1:200] $rose(rx_line));
endmodule
bind async_rx_clock_data_recovery rx_recovery_checker rx_recovery_checker_inst
  (.clk_sys, .rst, .rx_line, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .irq);

// ---- rx_tx_model.sv ----
// Purpose: remote asynchronous transmitter driving the serial line
// Assumes: bit time given in clock cycles
// Notes:   line idles high between frames
`timescale 1ns/100ps
module tx_model (
  input  wire logic clk_sys, // clock
  output logic      line     // serial line
);
  initial line = 1'b1;
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  // frame, bt clocks per bit, st clocks of stop bit
  task automatic frame(input logic [8:0] d, input int nb, input logic pen,
                       input logic pb, input logic stop, input int bt,
                       input int st);
    hold(1'b0, bt);
    for (int i = 0; i < nb; i++)
      hold(d[i], bt);
    if (pen)
      hold(pb, bt);
    hold(stop, st);
    if (!stop)
      hold(1'b1, bt);
  endtask
  task automatic glitch(input int n);
    hold(1'b0, n);
    line <= 1'b1;
  endtask
endmodule

// ---- async_rx_clock_data_recovery_tb.sv ----
// Purpose: register level test of the async receive front end
// Assumes: sample divisor programmed to 16 clocks
// Notes:   frames come from the transmitter model
`timescale 1ns/100ps
module async_rx_clock_data_recovery_tb;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL = rx_recovery_pkg::CTRL_OFFSET;
  localparam logic [7:0] DAT = rx_recovery_pkg::DATA_OFFSET;
  localparam logic [7:0] STA = rx_recovery_pkg::STATUS_OFFSET;
  localparam logic [7:0] IEN = rx_recovery_pkg::IRQ_EN_OFFSET;
  localparam logic [7:0] ICL = rx_recovery_pkg::IRQ_CLR_OFFSET;
  logic        clk_sys, rst, hsel, hwrite, irq, hreadyout, hresp, rx_line;
  logic        irq_on;
  logic [31:0] haddr, hwdata, hrdata, hr_mid, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          errors, tests_run, cycles;
  async_rx_clock_data_recovery async_rx_clock_data_recovery_inst (
    .clk_sys, .rst, .rx_line, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq);
  tx_model tx_model_inst (.clk_sys, .line(rx_line));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) hr_mid = hrdata;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hr_mid;
  endtask
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk_sys);
    check("irq", {31'h0, irq}, {31'h0, v});
  endtask
  task automatic run_frame(input logic dbl, pen, odd, bad, stop,
                           input logic [3:0] nb, input logic [8:0] d);
    logic [8:0] m;
    logic [2:0] fl;
    m = 9'h1FF >> (4'd9 - nb);
    fl = {pen & bad, !stop, 1'b1};
    bus(1'b1, CTL, {24'h00_0000, nb, odd, pen, dbl, 1'b1});
    tx_model_inst.frame(d & m, nb, pen, ^(d & m) ^ odd ^ bad, stop,
                        dbl ? 129 : 257, dbl ? 129 : 257);
    repeat (40) @(posedge clk_sys);
    rchk("status", STA, {29'h0, fl});
    irq_is(irq_on);
    rchk("data", DAT, {21'h0, fl[2:1], d & m});
    bus(1'b1, ICL, 32'h0000_000F);
    irq_is(1'b0);
    $display("frame test done");
  endtask
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    irq_on = 1'b1;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rchk("ctrl", CTL, 32'h0000_0031);
    rchk("baud", rx_recovery_pkg::BAUD_OFFSET, 32'h0000_0036);
    rchk("status", STA, 32'h0000_0000);
    rchk("unmapped", 8'h18, 32'h0000_0000);
    bus(1'b1, rx_recovery_pkg::BAUD_OFFSET, 32'h0000_000F);
    bus(1'b1, IEN, 32'h0000_000F);
    bus(1'b1, CTL, 32'h0000_0081);
    $display("reset test done");
    for (int n = 80; n <= 120; n += 40) begin
      tx_model_inst.glitch(n);
      repeat (300) @(posedge clk_sys);
      rchk("noise", STA, 32'h0000_0008);
      bus(1'b1, ICL, 32'h0000_000F);
      irq_is(1'b0);
    end
    $display("noise test done");
    run_frame(0, 0, 0, 0, 1, 4'd8, 9'h0A5);
    run_frame(1, 0, 0, 0, 1, 4'd8, 9'h03C);
    run_frame(0, 0, 0, 0, 1, 4'd5, 9'h0F5);
    run_frame(0, 1, 0, 0, 1, 4'd9, 9'h1A5);
    run_frame(0, 1, 1, 1, 1, 4'd7, 9'h05A);
    run_frame(1, 1, 1, 0, 1, 4'd6, 9'h02D);
    run_frame(0, 0, 0, 0, 0, 4'd8, 9'h0FF);
    run_frame(1, 1, 0, 1, 0, 4'd9, 9'h155);
    bus(1'b1, CTL, 32'h0000_0081);
    bus(1'b1, IEN, 32'h0000_0000);
    tx_model_inst.frame(9'h0C3, 8, 1'b0, 1'b0, 1'b1, 257, 180);
    tx_model_inst.frame(9'h05A, 8, 1'b0, 1'b0, 1'b1, 257, 257);
    repeat (40) @(posedge clk_sys);
    rchk("b2b status", STA, 32'h0000_0001);
    irq_is(1'b0);
    bus(1'b1, IEN, 32'h0000_0001);
    irq_is(1'b1);
    rchk("b2b data", DAT, 32'h0000_005A);
    irq_is(1'b0);
    $display("back to back test done");
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule
